// File: hdl/cfs_core.sv
// card side command interpreter: channels, file selection, template
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "cfs_params.svh"
module cfs_core (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // apb slave
    input wire cfs_pkg::cfs_apb_req_t apb_req,
    output cfs_pkg::cfs_apb_rsp_t apb_rsp
);
    typedef struct packed {
        cfs_pkg::cfs_state_t st;
        cfs_pkg::cfs_ent_t [`CFS_NENT-1:0] ent;
        cfs_pkg::cfs_chan_t [`CFS_NCH-1:0] ch;
        logic [`CFS_DBUF-1:0][7:0] dbuf;
        logic [4:0] dcnt;
        logic [7:0] cla;
        logic [7:0] ins;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] lc;
        logic lc_pres;
        logic [7:0] le;
        logic le_pres;
        logic [4:0] cur_ch;
        logic [2:0] idx;
        logic [1:0] pass;
        logic [3:0] ppos;
        logic [2:0] base;
        logic hit;
        logic [2:0] hit_i;
        logic [15:0] sw;
        logic done;
        logic ptr_ok;
        logic sess_term;
        logic fcp_req;
        logic [2:0] rfile;
        logic [5:0] rlen;
        logic [5:0] rpos;
        logic [2:0] tidx;
        logic [4:0] new_ch;
        logic [31:0] prdata;
    } cfs_core_st_t;

    cfs_core_st_t s_q;
    cfs_core_st_t s_d;
    logic [7:0] g_byte;
    logic [5:0] g_total;

    cfs_fcp_gen u_gen (
        .ent(s_q.ent[(s_q.st == cfs_pkg::ST_DONE) ? s_q.hit_i : s_q.rfile]),
        .idx(s_q.rpos[4:0]),
        .byte_o(g_byte),
        .total(g_total)
    );

    function automatic logic [4:0] chan_of(input logic [7:0] cla);
        // bit b7 of the class selects the extended coding
        if (cla[6]) begin
            chan_of = `CFS_EXT_BASE + {1'b0, cla[3:0]};
        end else begin
            chan_of = {3'b000, cla[1:0]};
        end
    endfunction

    function automatic logic aid_match(input logic [31:0] application_identifier, input logic [`CFS_DBUF-1:0][7:0] d,
                                       input logic [7:0] lc);
        // only the first lc bytes are compared, so a truncated name still hits
        aid_match = (lc != 8'h00) && (lc <= `CFS_AIDB);
        for (int k = 0; k < `CFS_AIDB; k++) begin
            if (k < lc && application_identifier[31-8*k -: 8] != d[k]) begin
                aid_match = 1'b0;
            end
        end
    endfunction

    logic acc;
    logic setup;
    logic wr;
    logic [7:0] a;
    logic [15:0] fid_in;
    logic [2:0] cdir;
    logic [2:0] par;
    logic [2:0] dirsel;
    logic em;
    logic kids;
    logic last;
    logic [4:0] fch;
    logic ffound;
    logic [4:0] chn;

    always_comb begin
        s_d = s_q;
        acc = apb_req.psel && apb_req.penable;
        setup = apb_req.psel && !apb_req.penable;
        wr = acc && apb_req.pwrite;
        a = apb_req.paddr;
        fid_in = {s_q.dbuf[s_q.ppos], s_q.dbuf[s_q.ppos + 4'h1]};
        cdir = s_q.ch[s_q.cur_ch].dir;
        par = s_q.ent[cdir].parent;
        em = 1'b0;
        kids = 1'b0;
        last = (s_q.idx == 3'(`CFS_NENT - 1));
        dirsel = 3'h0;
        chn = 5'h00;
        ffound = 1'b0;
        fch = 5'h00;
        // lowest free channel, never channel 0
        for (int k = `CFS_NCH - 1; k > 0; k--) begin
            if (!s_q.ch[k].open) begin
                fch = 5'(k);
                ffound = 1'b1;
            end
        end
        s_d.done = 1'b0;
        s_d.ch[0].open = 1'b1;

        // register read, captured in setup so data comes from a flop
        if (setup && !apb_req.pwrite) begin
            case (a)
                `CFS_A_CMD: s_d.prdata = {s_q.p2, s_q.p1, s_q.ins, s_q.cla};
                `CFS_A_LEN: s_d.prdata = {7'h00, s_q.le_pres, s_q.le, 7'h00, s_q.lc_pres, s_q.lc};
                `CFS_A_STAT: s_d.prdata = {s_q.sw, 6'h00, s_q.new_ch, 3'h0,
                                          (s_q.st != cfs_pkg::ST_IDLE), s_q.done};
                `CFS_A_CUR: s_d.prdata = {8'h00, 3'h0, s_q.cur_ch, 6'h00, s_q.sess_term, s_q.ptr_ok,
                                         1'b0, s_q.ch[s_q.cur_ch].file, 1'b0, cdir};
                `CFS_A_RESP: s_d.prdata = {23'h000000, (s_q.rpos < s_q.rlen), g_byte};
                `CFS_A_TIDX: s_d.prdata = {29'h00000000, s_q.tidx};
                `CFS_A_TENT: s_d.prdata = {10'h000, s_q.ent[s_q.tidx].valid, s_q.ent[s_q.tidx].kind,
                                          s_q.ent[s_q.tidx].parent, s_q.ent[s_q.tidx].file_identifier};
                `CFS_A_TAID: s_d.prdata = s_q.ent[s_q.tidx].application_identifier;
                `CFS_A_TSZ: s_d.prdata = {16'h0000, s_q.ent[s_q.tidx].size};
                default: s_d.prdata = 32'h0000_0000;
            endcase
        end

        // response bytes are consumed as software reads them
        if (acc && !apb_req.pwrite && a == `CFS_A_RESP && s_q.rpos < s_q.rlen) begin
            s_d.rpos = s_q.rpos + 6'h01;
        end

        if (wr) begin
            case (a)
                `CFS_A_CMD: begin
                    {s_d.p2, s_d.p1, s_d.ins, s_d.cla} = apb_req.pwdata;
                end
                `CFS_A_LEN: begin
                    s_d.lc = apb_req.pwdata[7:0];
                    s_d.lc_pres = apb_req.pwdata[8];
                    s_d.le = apb_req.pwdata[23:16];
                    s_d.le_pres = apb_req.pwdata[24];
                end
                `CFS_A_DATA: begin
                    // bytes beyond the buffer are dropped
                    if (s_q.dcnt < 5'(`CFS_DBUF)) begin
                        s_d.dbuf[s_q.dcnt[3:0]] = apb_req.pwdata[7:0];
                        s_d.dcnt = s_q.dcnt + 5'h01;
                    end
                end
                `CFS_A_CTRL: begin
                    if (apb_req.pwdata[1]) begin
                        s_d.dcnt = 5'h00;
                    end
                    if (apb_req.pwdata[2]) begin
                        s_d.ptr_ok = 1'b1;
                    end
                end
                `CFS_A_TIDX: s_d.tidx = apb_req.pwdata[2:0];
                `CFS_A_TENT: begin
                    s_d.ent[s_q.tidx].file_identifier = apb_req.pwdata[15:0];
                    s_d.ent[s_q.tidx].parent = apb_req.pwdata[18:16];
                    s_d.ent[s_q.tidx].kind = cfs_pkg::cfs_kind_t'(apb_req.pwdata[20:19]);
                    s_d.ent[s_q.tidx].valid = apb_req.pwdata[21];
                end
                `CFS_A_TAID: s_d.ent[s_q.tidx].application_identifier = apb_req.pwdata;
                `CFS_A_TSZ: s_d.ent[s_q.tidx].size = apb_req.pwdata[15:0];
                default: begin
                end
            endcase
        end

        case (s_q.st)
            cfs_pkg::ST_IDLE: begin
                if (wr && a == `CFS_A_CTRL && apb_req.pwdata[0]) begin
                    chn = chan_of(s_q.cla);
                    s_d.cur_ch = chn;
                    s_d.idx = 3'h0;
                    s_d.pass = 2'h0;
                    s_d.ppos = 4'h0;
                    s_d.hit = 1'b0;
                    s_d.rlen = 6'h00;
                    s_d.rpos = 6'h00;
                    s_d.st = cfs_pkg::ST_DONE;
                    s_d.sw = `CFS_SW_OK;
                    if (chn >= 5'(`CFS_NCH) || !s_q.ch[chn].open) begin
                        s_d.sw = `CFS_SW_CH_CLOSED;
                    end else if (s_q.ins == `CFS_INS_MANAGE) begin
                        if (s_q.p1 == `CFS_MC_OPEN) begin
                            if (ffound) begin
                                s_d.ch[fch] = '{open: 1'b1, dir: 3'h0, file: 3'h0};
                                s_d.new_ch = fch;
                            end else begin
                                s_d.sw = `CFS_SW_NO_CHAN;
                            end
                        end else if (s_q.p1 == `CFS_MC_CLOSE) begin
                            chn = (s_q.p2 == 8'h00) ? chn : s_q.p2[4:0];
                            if (chn == 5'h00 || chn >= 5'(`CFS_NCH)) begin
                                s_d.sw = `CFS_SW_BAD_P1P2;
                            end else begin
                                s_d.ch[chn].open = 1'b0;
                            end
                        end else begin
                            s_d.sw = `CFS_SW_BAD_P1P2;
                        end
                    end else if (s_q.ins != `CFS_INS_SELECT) begin
                        s_d.sw = `CFS_SW_INS_UNSUP;
                    end else begin
                        // select: decide method; session bits only mean something for aid
                        s_d.fcp_req = !s_q.p2[7] && s_q.p2[4:2] == `CFS_FCP_RET;
                        s_d.base = (s_q.p1 == `CFS_P1_PATH_ROOT) ? 3'h0 : s_q.ch[chn].dir;
                        case (s_q.p1)
                            `CFS_P1_FID: begin
                                if (!s_q.lc_pres || s_q.lc == 8'h00) begin
                                    s_d.hit = 1'b1;
                                    s_d.hit_i = 3'h0;
                                end else begin
                                    s_d.st = cfs_pkg::ST_SCAN;
                                end
                            end
                            `CFS_P1_PARENT: begin
                                s_d.hit = 1'b1;
                                s_d.hit_i = s_q.ent[s_q.ch[chn].dir].parent;
                            end
                            `CFS_P1_CHILD, `CFS_P1_AID, `CFS_P1_PATH_ROOT, `CFS_P1_PATH_CUR: begin
                                s_d.st = cfs_pkg::ST_SCAN;
                            end
                            default: s_d.sw = `CFS_SW_BAD_P1P2;
                        endcase
                    end
                end
            end
            cfs_pkg::ST_SCAN: begin
                s_d.idx = s_q.idx + 3'h1;
                case (s_q.p1)
                    `CFS_P1_AID: begin
                        em = s_q.ent[s_q.idx].valid && s_q.ent[s_q.idx].kind == cfs_pkg::K_ADF &&
                             aid_match(s_q.ent[s_q.idx].application_identifier, s_q.dbuf, s_q.lc);
                        // occurrence control, b2 b1 ignored for other methods
                        case (s_q.p2[1:0])
                            2'b00: kids = em && !s_d.hit;
                            2'b01: kids = em;
                            2'b10: kids = em && !s_d.hit && s_q.idx > s_q.ch[s_q.cur_ch].file;
                            default: kids = em && s_q.idx < s_q.ch[s_q.cur_ch].file;
                        endcase
                        if (kids) begin
                            s_d.hit = 1'b1;
                            s_d.hit_i = s_q.idx;
                        end
                        if (last) begin
                            s_d.st = cfs_pkg::ST_DONE;
                        end
                    end
                    `CFS_P1_FID: begin
                        // three passes keep the search order deterministic
                        case (s_q.pass)
                            2'h0: em = s_q.ent[s_q.idx].parent == cdir && s_q.idx != cdir;
                            2'h1: em = s_q.idx == par;
                            default: em = s_q.ent[s_q.idx].parent == par && s_q.idx != par;
                        endcase
                        if (em && s_q.ent[s_q.idx].valid && s_q.ent[s_q.idx].file_identifier == fid_in) begin
                            s_d.hit = 1'b1;
                            s_d.hit_i = s_q.idx;
                            s_d.st = cfs_pkg::ST_DONE;
                        end else if (last) begin
                            s_d.pass = s_q.pass + 2'h1;
                            if (s_q.pass == 2'h2) begin
                                s_d.st = cfs_pkg::ST_DONE;
                            end
                        end
                    end
                    default: begin
                        // child and path walks share one child matcher
                        em = s_q.ent[s_q.idx].valid && s_q.ent[s_q.idx].parent == s_q.base &&
                             s_q.idx != s_q.base && s_q.ent[s_q.idx].file_identifier == fid_in;
                        if (s_q.p1 == `CFS_P1_CHILD) begin
                            em = em && s_q.ent[s_q.idx].kind != cfs_pkg::K_EF;
                        end
                        if (em && ({4'h0, s_q.ppos} + 8'h2 >= s_q.lc || s_q.p1 == `CFS_P1_CHILD)) begin
                            s_d.hit = 1'b1;
                            s_d.hit_i = s_q.idx;
                            s_d.st = cfs_pkg::ST_DONE;
                        end else if (em && s_q.ent[s_q.idx].kind != cfs_pkg::K_EF) begin
                            s_d.base = s_q.idx;
                            s_d.ppos = s_q.ppos + 4'h2;
                            s_d.idx = 3'h0;
                        end else if (last) begin
                            s_d.st = cfs_pkg::ST_DONE;
                        end
                    end
                endcase
            end
            cfs_pkg::ST_DONE: begin
                s_d.st = cfs_pkg::ST_IDLE;
                s_d.done = 1'b1;
                if (s_q.ins == `CFS_INS_SELECT && s_q.sw == `CFS_SW_OK) begin
                    if (s_q.hit) begin
                        dirsel = s_q.hit_i;
                        s_d.rfile = dirsel;
                        s_d.ch[s_q.cur_ch].file = dirsel;
                        if (s_q.ent[dirsel].kind != cfs_pkg::K_EF) begin
                            s_d.ch[s_q.cur_ch].dir = dirsel;
                        end
                        s_d.ptr_ok = 1'b0;
                        if (s_q.p1 == `CFS_P1_AID) begin
                            s_d.sess_term = s_q.p2[6:5] == `CFS_SESS_TERM;
                        end
                        if (s_q.fcp_req) begin
                            s_d.rlen = g_total;
                            // a nonzero expected length below the template length truncates the template
                            if (s_q.le_pres && s_q.le != 8'h00 && s_q.le < {2'h0, g_total}) begin
                                s_d.rlen = s_q.le[5:0];
                            end
                        end
                    end else begin
                        s_d.sw = `CFS_SW_NOT_FOUND;
                    end
                end
            end
            default: s_d.st = cfs_pkg::ST_IDLE;
        endcase
    end

    assign apb_rsp.prdata = s_q.prdata;
    assign apb_rsp.pready = apb_req.psel && apb_req.penable;
    assign apb_rsp.pslverr = 1'b0;

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
            s_q.st <= cfs_pkg::ST_IDLE;
            s_q.ent[0].valid <= 1'b1;
            s_q.ent[0].kind <= cfs_pkg::K_ROOT;
            s_q.ch[0].open <= 1'b1;
            s_q.sw <= `CFS_SW_OK;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

// File: hdl/cfs_fcp_gen.sv
// file control template byte generator
`timescale 1ns/10ps
`default_nettype none
`include "cfs_params.svh"
module cfs_fcp_gen (
    // selected file
    input wire cfs_pkg::cfs_ent_t ent,
    // byte lookup
    input wire logic [4:0] idx,
    output logic [7:0] byte_o,
    output logic [5:0] total
);
    logic [7:0] b [0:31];
    int p;
    always_comb begin
        for (int k = 0; k < 32; k++) begin
            b[k] = 8'h00;
        end
        b[0] = `CFS_TAG_FCP;
        p = 2;
        // descriptor and identifier first, then aid or A5 object, then life cycle, in fixed order; new objects go last
        b[p] = `CFS_TAG_DESC;
        b[p+1] = 8'h02;
        b[p+2] = (ent.kind == cfs_pkg::K_EF) ? `CFS_FD_EF : `CFS_FD_DIR;
        b[p+3] = `CFS_DCB;
        p = p + 4;
        b[p] = `CFS_TAG_FID;
        b[p+1] = 8'h02;
        b[p+2] = ent.file_identifier[15:8];
        b[p+3] = ent.file_identifier[7:0];
        p = p + 4;
        if (ent.kind == cfs_pkg::K_ADF) begin
            b[p] = `CFS_TAG_AID;
            b[p+1] = 8'h04;
            b[p+2] = ent.application_identifier[31:24];
            b[p+3] = ent.application_identifier[23:16];
            b[p+4] = ent.application_identifier[15:8];
            b[p+5] = ent.application_identifier[7:0];
            p = p + 6;
        end
        if (ent.kind == cfs_pkg::K_ROOT) begin
            b[p] = `CFS_TAG_PROP;
            b[p+1] = 8'h00;
            p = p + 2;
        end
        b[p] = `CFS_TAG_LCS;
        b[p+1] = 8'h01;
        b[p+2] = `CFS_LCS_OP;
        p = p + 3;
        if (ent.kind == cfs_pkg::K_EF) begin
            // one security object only, then size
            b[p] = `CFS_TAG_SEC;
            b[p+1] = 8'h01;
            b[p+2] = 8'h00;
            b[p+3] = `CFS_TAG_SIZE;
            b[p+4] = 8'h02;
            b[p+5] = ent.size[15:8];
            b[p+6] = ent.size[7:0];
            p = p + 7;
        end else begin
            b[p] = `CFS_TAG_PIN;
            b[p+1] = 8'h00;
            p = p + 2;
        end
        b[1] = 8'(p - 2);
        total = 6'(p);
        byte_o = b[idx];
    end
endmodule
`default_nettype wire

// File: hdl/cfs_params.svh
// constants for the card file select block
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH
`define CFS_A_CMD 8'h00
`define CFS_A_LEN 8'h04
`define CFS_A_DATA 8'h08
`define CFS_A_CTRL 8'h0C
`define CFS_A_STAT 8'h10
`define CFS_A_CUR 8'h14
`define CFS_A_RESP 8'h18
`define CFS_A_TIDX 8'h20
`define CFS_A_TENT 8'h24
`define CFS_A_TAID 8'h28
`define CFS_A_TSZ 8'h2C
`define CFS_INS_SELECT 8'hA4
`define CFS_INS_MANAGE 8'h70
`define CFS_P1_FID 8'h00
`define CFS_P1_CHILD 8'h01
`define CFS_P1_PARENT 8'h03
`define CFS_P1_AID 8'h04
`define CFS_P1_PATH_ROOT 8'h08
`define CFS_P1_PATH_CUR 8'h09
`define CFS_MC_OPEN 8'h00
`define CFS_MC_CLOSE 8'h80
`define CFS_SW_OK 16'h9000
`define CFS_SW_INS_UNSUP 16'h6D00
`define CFS_SW_BAD_P1P2 16'h6A86
`define CFS_SW_NOT_FOUND 16'h6A82
`define CFS_SW_NO_CHAN 16'h6A81
`define CFS_SW_CH_CLOSED 16'h6881
`define CFS_FCP_RET 3'b001
`define CFS_FCP_NONE 3'b011
`define CFS_SESS_TERM 2'b10
`define CFS_EXT_BASE 5'h04
`define CFS_NCH 20
`define CFS_NENT 8
`define CFS_AIDB 4
`define CFS_DBUF 16
`define CFS_TAG_FCP 8'h62
`define CFS_TAG_DESC 8'h82
`define CFS_TAG_FID 8'h83
`define CFS_TAG_AID 8'h84
`define CFS_TAG_PROP 8'hA5
`define CFS_TAG_LCS 8'h8A
`define CFS_TAG_SEC 8'h8C
`define CFS_TAG_PIN 8'hC6
`define CFS_TAG_SIZE 8'h80
`define CFS_FD_DIR 8'h38
`define CFS_FD_EF 8'h01
`define CFS_DCB 8'h21
`define CFS_LCS_OP 8'h05
`endif

// File: hdl/cfs_pkg.sv
// types for the card file select block
package cfs_pkg;
    typedef enum logic [1:0] {K_ROOT, K_DF, K_ADF, K_EF} cfs_kind_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_DONE} cfs_state_t;
    typedef struct packed {
        logic valid;
        cfs_kind_t kind;
        logic [2:0] parent;
        logic [15:0] file_identifier;
        logic [31:0] application_identifier;
        logic [15:0] size;
    } cfs_ent_t;
    typedef struct packed {
        logic open;
        logic [2:0] dir;
        logic [2:0] file;
    } cfs_chan_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } cfs_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cfs_apb_rsp_t;
endpackage

// File: test/cfs_core_sva.sv
// apb port assertions for the card file select core
`timescale 1ns/10ps
`default_nettype none
`include "cfs_params.svh"
module cfs_core_sva (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // apb
    input wire cfs_pkg::cfs_apb_req_t apb_req,
    input wire cfs_pkg::cfs_apb_rsp_t apb_rsp
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    wire logic rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    wire logic [7:0] a = apb_req.paddr;
    a_ready_zero_wait: assert property (apb_rsp.pready == (apb_req.psel && apb_req.penable))
        else $error("pready not tied to access phase");
    a_no_slave_err: assert property (!apb_rsp.pslverr) else $error("pslverr raised");
    a_rdata_holds: assert property (rd_acc |=> $stable(apb_rsp.prdata)) else $error("read data moved");
    a_unmapped_zero: assert property (rd_acc && a == 8'h1C |-> apb_rsp.prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_wonly_zero: assert property (rd_acc && a inside {`CFS_A_DATA, `CFS_A_CTRL} |-> apb_rsp.prdata == 32'h0000_0000)
        else $error("write-only read not zero");
    a_sw_known: assert property (rd_acc && a == `CFS_A_STAT |-> apb_rsp.prdata[31:16] inside
        {16'h9000, 16'h6D00, 16'h6A86, 16'h6A82, 16'h6A81, 16'h6881}) else $error("odd status");
    a_chan_range: assert property (rd_acc && a == `CFS_A_CUR |-> apb_rsp.prdata[20:16] < 5'd20)
        else $error("channel out of range");
    a_reset_clears: assert property (disable iff (1'b0) srst |=> apb_rsp.prdata == 32'h0000_0000)
        else $error("read data not cleared by reset");
endmodule
bind cfs_core cfs_core_sva cfs_core_sva_i (.mclk(mclk), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp));
`default_nettype wire

// File: test/cfs_term.sv
// terminal model: apb master that issues command frames
`timescale 1ns/10ps
`default_nettype none
module cfs_term (
    // clock
    input wire logic mclk,
    // bus towards the card
    output var cfs_pkg::cfs_apb_req_t apb_req,
    input wire cfs_pkg::cfs_apb_rsp_t apb_rsp
);
    initial apb_req = '0;
    // idle edge first, so a release is never overwritten in the same step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        do @(posedge mclk); while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        apb_req <= '0;
    endtask
endmodule
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the card file select core
`timescale 1ns/10ps
`default_nettype none
`include "cfs_params.svh"
module tb;
    typedef struct packed {logic [31:0] cmd; logic [7:0] lc; logic [15:0] dat; logic [15:0] sw;} cfs_row_t;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    cfs_pkg::cfs_apb_req_t apb_req;
    cfs_pkg::cfs_apb_rsp_t apb_rsp;
    int errors = 0;
    int n_compared = 0;
    logic [31:0] r;
    // p2 low bits kept zero outside aid selection
    cfs_row_t rows [12] = '{
        '{32'h0000_B000, 8'h00, 16'h0000, 16'h6D00},
        '{32'h0C02_A400, 8'h00, 16'h0000, 16'h6A86},
        '{32'h0C00_A400, 8'h00, 16'h0000, 16'h9000},
        '{32'h0C03_A400, 8'h00, 16'h0000, 16'h9000},
        '{32'h0C01_A400, 8'h02, 16'h7F10, 16'h6A82},
        '{32'h0C04_A400, 8'h02, 16'hA000, 16'h6A82},
        '{32'h0C08_A400, 8'h02, 16'h7F10, 16'h6A82},
        '{32'h0C09_A400, 8'h02, 16'h7F10, 16'h6A82},
        '{32'h0C00_A400, 8'h02, 16'h7F10, 16'h6A82},
        '{32'h0080_7000, 8'h00, 16'h0000, 16'h6A86},
        '{32'h0C03_A401, 8'h00, 16'h0000, 16'h6881},
        '{32'h0C03_A440, 8'h00, 16'h0000, 16'h6881}};
    cfs_core cfs_core_i (.mclk(mclk), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp));
    cfs_term cfs_term_i (.mclk(mclk), .apb_req(apb_req), .apb_rsp(apb_rsp));
    always #4 mclk = ~mclk;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cfs_term_i.xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a);
        cfs_term_i.xfer(1'b0, a, 32'h0000_0000, r);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // expected length zero asks for the whole template
    task automatic run(input cfs_row_t x);
        wr(`CFS_A_CMD, x.cmd);
        wr(`CFS_A_LEN, {7'h00, 1'b1, 8'h00, 7'h00, x.lc != 8'h00, x.lc});
        wr(`CFS_A_CTRL, 32'h0000_0002);
        if (x.lc != 8'h00) begin
            wr(`CFS_A_DATA, {24'h00_0000, x.dat[15:8]});
            wr(`CFS_A_DATA, {24'h00_0000, x.dat[7:0]});
        end
        wr(`CFS_A_CTRL, 32'h0000_0001);
        do rd(`CFS_A_STAT); while (r[1] !== 1'b0);
    endtask
    task automatic resp(input logic [159:0] e, input int n);
        for (int i = 0; i < n; i++) begin
            rd(`CFS_A_RESP);
            chk({23'h00_0000, r[8:0]}, {24'h00_0001, e[8*(n-1-i) +: 8]});
        end
        rd(`CFS_A_RESP);
        chk({31'h0, r[8]}, 32'h0000_0000);
    endtask
    task automatic summarize;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        rd(`CFS_A_STAT);
        chk(r, 32'h9000_0000);
        rd(8'h1C);
        chk(r, 32'h0000_0000);
        rd(`CFS_A_DATA);
        chk(r, 32'h0000_0000);
        foreach (rows[i]) begin
            run(rows[i]);
            chk({16'h0000, r[31:16]}, {16'h0000, rows[i].sw});
        end
        // elementary file at table slot 1 under the root
        wr(`CFS_A_TIDX, 32'h0000_0001);
        wr(`CFS_A_TENT, 32'h0038_2F00);
        wr(`CFS_A_TSZ, 32'h0000_0010);
        wr(`CFS_A_CTRL, 32'h0000_0004);
        run('{32'h0400_A400, 8'h02, 16'h2F00, 16'h0000});
        chk({16'h0000, r[31:16]}, 32'h0000_9000);
        rd(`CFS_A_CUR);
        chk({28'h000_0000, r[8], r[6:4]}, 32'h0000_0001);
        resp(160'h6212_8202_0121_8302_2F00_8A01_058C_0100_8002_0010, 20);
        run('{32'h0403_A400, 8'h00, 16'h0000, 16'h0000});
        // model interprets no tag: every object, known or not, is passed over byte by byte
        resp(160'h620F_8202_3821_8302_0000_A500_8A01_05C6_00, 17);
        run('{32'h0000_7000, 8'h00, 16'h0000, 16'h0000});
        chk({27'h0, r[9:5]}, 32'h0000_0001);
        run('{32'h0C03_A401, 8'h00, 16'h0000, 16'h0000});
        chk({16'h0000, r[31:16]}, 32'h0000_9000);
        srst <= 1'b1;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        rd(`CFS_A_CUR);
        chk(r, 32'h0000_0000);
        summarize();
    end
endmodule
`default_nettype wire
